// ---- core/pcg_gating_group.v ----
// peripheral clock gating group: three gating registers, mode select, gates, fault flags
// assumes an AHB-Lite master with a single slave, and power mode levels from logic on mclk_i
//
// Behaviour
// [R1] a set gating bit clocks its unit; a clear bit leaves it unclocked
// [R2] an access to a unit whose clock is off raises a bus fault
// [R3] every gating bit resets to zero, all units unclocked
// [R4] separate run, sleep and deep-sleep gating registers for the same units
// [R5] auto-gating set selects sleep or deep-sleep register in those modes
// [R6] deep-sleep register bits 25 and 24 gate comparators b and a
// [R7] bits 18, 17, 16 gate general-purpose timers c, b, a
// [R8] bit 4 gates the synchronous port, bit 0 the asynchronous port
// [R9] reserved bits are read-only and read as zero
// [R10] with auto-gating clear the run register governs in every mode
// [R11] gated clocks switch without glitches or shortened pulses
`timescale 1ns/100ps
`include "pcg_regs.vh"
module pcg_gating_group (
   // clock and reset
   input  wire        mclk_i,
   input  wire        reset_i,
   // ahb-lite slave
   input  wire        hsel_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [11:0] haddr_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg         hreadyout_o,
   output reg         hresp_o,
   output reg  [31:0] hrdata_o,
   // power mode
   input  wire        sleep_i,
   input  wire        deep_sleep_i,
   // unit access strobes, order comp_b comp_a timer_c timer_b timer_a ssp asp
   input  wire [6:0]  unit_access_i,
   // unit clocks and faults
   output wire [6:0]  unit_clk_o,
   output reg         bus_fault_o,
   output reg  [6:0]  unit_fault_o
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   reg  [31:0] run_clock_gate_1;
   reg  [31:0] sleep_clock_gate_1;
   reg  [31:0] deep_sleep_clock_gate_1;
   reg         auto_gating_select;
   reg         wr_pend;
   reg  [11:0] wr_addr;
   reg  [6:0]  active_gate;
   reg  [31:0] next_rdata;
   reg  [31:0] sel_gate;
   reg  [31:0] wr_val;

   wire        take = hsel_i & htrans_i[1] & hready_i;
   wire [31:0] wmask = hwdata_i & `PCG_GATE_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, always okay

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_pend     <= 1'b0;
         wr_addr     <= 12'h000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         wr_pend     <= take & hwrite_i;
         wr_addr     <= haddr_i;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // reserved bits are masked off on write, so they always read zero [R9]
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         run_clock_gate_1        <= `PCG_GATE_RESET; // [R3]
         sleep_clock_gate_1      <= `PCG_GATE_RESET; // [R3]
         deep_sleep_clock_gate_1 <= `PCG_GATE_RESET; // [R3]
         auto_gating_select      <= `PCG_CFG_RESET;
      end else if (wr_pend) begin
         case (wr_addr)
            `PCG_RUN_GATE_OFS:   run_clock_gate_1        <= wmask; // [R4] [R9]
            `PCG_SLEEP_GATE_OFS: sleep_clock_gate_1      <= wmask; // [R4] [R9]
            `PCG_DEEP_GATE_OFS:  deep_sleep_clock_gate_1 <= wmask; // [R4] [R6] [R9]
            `PCG_RUN_CFG_OFS:    auto_gating_select      <= hwdata_i[`PCG_AUTO_GATE_BIT];
            default: begin
            end
         endcase
      end
   end

   // read data with forwarding of a write still in its data phase
   always @* begin
      wr_val     = (wr_pend && wr_addr == haddr_i) ? wmask : 32'h00000000;
      next_rdata = 32'h00000000;
      case (haddr_i)
         `PCG_RUN_GATE_OFS:   next_rdata = (wr_pend && wr_addr == haddr_i) ? wr_val : run_clock_gate_1;
         `PCG_SLEEP_GATE_OFS: next_rdata = (wr_pend && wr_addr == haddr_i) ? wr_val : sleep_clock_gate_1;
         `PCG_DEEP_GATE_OFS:  next_rdata = (wr_pend && wr_addr == haddr_i) ? wr_val : deep_sleep_clock_gate_1;
         `PCG_RUN_CFG_OFS: begin
            if (wr_pend && wr_addr == haddr_i) begin
               next_rdata[`PCG_AUTO_GATE_BIT] = hwdata_i[`PCG_AUTO_GATE_BIT];
            end else begin
               next_rdata[`PCG_AUTO_GATE_BIT] = auto_gating_select;
            end
         end
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         hrdata_o <= 32'h00000000;
      end else if (take & ~hwrite_i) begin
         hrdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode selection of the governing register

   always @* begin
      if (auto_gating_select && deep_sleep_i) begin
         sel_gate = deep_sleep_clock_gate_1; // [R5]
      end else if (auto_gating_select && sleep_i) begin
         sel_gate = sleep_clock_gate_1; // [R5]
      end else begin
         sel_gate = run_clock_gate_1; // [R10]
      end
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         active_gate <= 7'h00;
      end else begin
         active_gate <= {sel_gate[`PCG_COMP_B_BIT], sel_gate[`PCG_COMP_A_BIT],   // [R6]
                         sel_gate[`PCG_TIMER_C_BIT], sel_gate[`PCG_TIMER_B_BIT], // [R7]
                         sel_gate[`PCG_TIMER_A_BIT],                             // [R7]
                         sel_gate[`PCG_SSP_BIT], sel_gate[`PCG_ASP_BIT]};        // [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gated clocks; outputs are gated clocks, not flops, by nature

   genvar gi;
   generate
      for (gi = 0; gi < `PCG_UNITS; gi = gi + 1) begin : g_gate
         pcg_clock_gate u_gate (
            .clk_i    (mclk_i),
            .reset_i  (reset_i),
            .enable_i (active_gate[gi]),
            .gclk_o   (unit_clk_o[gi])
         ); // [R1] [R11]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // bus fault on access to an unclocked unit

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         unit_fault_o <= 7'h00;
         bus_fault_o  <= 1'b0;
      end else begin
         unit_fault_o <= unit_access_i & ~active_gate;    // [R2]
         bus_fault_o  <= |(unit_access_i & ~active_gate); // [R2]
      end
   end

endmodule

// ---- pkg/pcg_regs.vh ----
// register offsets, field positions and reset values of the peripheral clock gating group
// included by pcg_gating_group and the verification files; holds definitions only
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// byte offsets
`define PCG_RUN_CFG_OFS     12'h060
`define PCG_RUN_GATE_OFS    12'h104
`define PCG_SLEEP_GATE_OFS  12'h114
`define PCG_DEEP_GATE_OFS   12'h124

// gating fields
`define PCG_COMP_B_BIT      25
`define PCG_COMP_A_BIT      24
`define PCG_TIMER_C_BIT     18
`define PCG_TIMER_B_BIT     17
`define PCG_TIMER_A_BIT     16
`define PCG_SSP_BIT         4
`define PCG_ASP_BIT         0
`define PCG_GATE_MASK       32'h03070011

// configuration fields
`define PCG_AUTO_GATE_BIT   27

// reset values
`define PCG_GATE_RESET      32'h00000000
`define PCG_CFG_RESET       1'h0

// unit count
`define PCG_UNITS           7

`endif

// ---- core/pcg_clock_gate.v ----
// one glitch-free clock gate for a single unit
// assumes clk_i is the free-running system clock
`timescale 1ns/100ps
module pcg_clock_gate (
   // clock and reset
   input  wire clk_i,
   input  wire reset_i,
   // control
   input  wire enable_i,
   // gated clock
   output wire gclk_o
);

   reg enable_low;

   // enable moves only while the clock is low, so no runt pulse [R11]
   always @(negedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         enable_low <= 1'b0;
      end else begin
         enable_low <= enable_i;
      end
   end

   assign gclk_o = clk_i & enable_low; // [R1]

endmodule

// ---- verification/pcg_gating_props.sv ----
// assertions on the ports of the clock gating group
// assumes one ahb-lite master and single-cycle access strobes
`timescale 1ns/100ps
`include "pcg_regs.vh"
module pcg_gating_props (
   // clock, reset and bus
   input  wire        mclk_i,
   input  wire        reset_i,
   input  wire        hsel_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [11:0] haddr_i,
   input  wire        hready_i,
   input  wire        hreadyout_o,
   input  wire        hresp_o,
   input  wire [31:0] hrdata_o,
   // faults
   input  wire [6:0]  unit_access_i,
   input  wire        bus_fault_o,
   input  wire [6:0]  unit_fault_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   wire rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   wire gt = haddr_i == `PCG_RUN_GATE_OFS || haddr_i == `PCG_SLEEP_GATE_OFS || haddr_i == `PCG_DEEP_GATE_OFS;
   ////////////////////////////////////////////////////////////////////////////////
   a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
   a_fault_cause: assert property ((unit_fault_o & ~$past(unit_access_i)) == 7'h00) else $error("fault without access");
   a_fault_summary: assert property (bus_fault_o == (unit_fault_o != 7'h00)) else $error("fault summary wrong");
   a_fault_ends: assert property (unit_access_i == 7'h00 |=> !bus_fault_o) else $error("fault outlives access");
   a_reserved_zero: assert property (rd && gt |=> (hrdata_o & ~`PCG_GATE_MASK) == 32'h00000000) else $error("reserved set");
   a_cfg_bits: assert property (rd && haddr_i == `PCG_RUN_CFG_OFS |=> (hrdata_o & ~32'h08000000) == 32'h00000000) else $error("cfg bits");
   a_unmapped_zero: assert property (rd && !gt && haddr_i != `PCG_RUN_CFG_OFS |=> hrdata_o == 32'h00000000) else $error("unmapped");
   a_rdata_hold: assert property (!rd |=> $stable(hrdata_o)) else $error("read data moved");
   cover property (rd && gt);
   cover property (bus_fault_o);
   cover property (unit_access_i != 7'h00 ##1 !bus_fault_o);
endmodule
bind pcg_gating_group pcg_gating_props pcg_gating_props_inst (.mclk_i, .reset_i, .hsel_i, .htrans_i, .hwrite_i,
   .haddr_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .unit_access_i, .bus_fault_o, .unit_fault_o);

// ---- verification/pcg_gating_group_bench.sv ----
// self-checking bench for the clock gating group
// assumes hready is looped back from the one slave
`timescale 1ns/100ps
`include "pcg_regs.vh"
module pcg_gating_group_bench;
   reg         mclk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg         hsel_i = 1'b0;
   reg         hwrite_i = 1'b0;
   reg         sleep_i = 1'b0;
   reg         deep_sleep_i = 1'b0;
   reg  [1:0]  htrans_i = 2'h0;
   reg  [11:0] haddr_i = 12'h000;
   reg  [31:0] hwdata_i = 32'h00000000;
   reg  [6:0]  unit_access_i = 7'h00;
   wire        hreadyout_o, hresp_o, bus_fault_o;
   wire [31:0] hrdata_o;
   wire [6:0]  unit_clk_o, unit_fault_o;
   integer     mismatches = 0;
   integer     comparisons = 0;
   integer     i;
   reg  [31:0] rd;
   always #2 mclk_i = ~mclk_i;
   pcg_gating_group pcg_gating_group_inst (.mclk_i, .reset_i, .hsel_i, .htrans_i, .hwrite_i, .haddr_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .sleep_i,
      .deep_sleep_i, .unit_access_i, .unit_clk_o, .bus_fault_o, .unit_fault_o);
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      begin
         if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [47:0] what, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // bounded wait: hready is sampled at the edge that ends each phase
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge mclk_i);
         while (hreadyout_o !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
               mismatches = mismatches + 1;
               conclude;
            end
            @(posedge mclk_i);
         end
      end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      begin
         hsel_i <= 1'b1;
         htrans_i <= 2'h2;
         hwrite_i <= w;
         haddr_i <= a;
         wait_rdy;
         hsel_i <= 1'b0;
         htrans_i <= 2'h0;
         hwdata_i <= d;
         wait_rdy;
         rd = hrdata_o;
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] exp);
      begin
         xfer(1'b0, a, 32'h00000000);
         chk("rdata", exp, rd);
      end
   endtask
   function [6:0] m(input [31:0] v);
      m = {v[25], v[24], v[18], v[17], v[16], v[4], v[0]};
   endfunction
   // strobe every unit, then judge faults and clocks mid high phase
   task probe(input [6:0] en);
      begin
         repeat (4) @(posedge mclk_i);
         unit_access_i <= 7'h7F;
         @(posedge mclk_i);
         unit_access_i <= 7'h00;
         #1;
         chk("fault", {25'h0, ~en}, {25'h0, unit_fault_o});
         chk("busflt", {31'h0, en != 7'h7F}, {31'h0, bus_fault_o});
         chk("clock", {25'h0, en}, {25'h0, unit_clk_o});
         @(posedge mclk_i);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         rdchk(`PCG_RUN_GATE_OFS, 32'h00000000);
         rdchk(`PCG_SLEEP_GATE_OFS, 32'h00000000);
         rdchk(`PCG_DEEP_GATE_OFS, 32'h00000000);
         rdchk(`PCG_RUN_CFG_OFS, 32'h00000000);
         xfer(1'b1, 12'h200, 32'hFFFFFFFF);
         rdchk(12'h200, 32'h00000000);
         probe(7'h00);
      end
   endtask
   task t_fields;
      begin
         xfer(1'b1, `PCG_RUN_GATE_OFS, 32'hFFFFFFFF);
         rdchk(`PCG_RUN_GATE_OFS, 32'h03070011);
         probe(7'h7F);
         for (i = 0; i < 32; i = i + 1)
            if (`PCG_GATE_MASK >> i & 1) begin
               xfer(1'b1, `PCG_RUN_GATE_OFS, 32'h1 << i);
               probe(m(32'h1 << i));
            end
      end
   endtask
   // low-power registers only count when auto-gating is set; deep sleep wins
   task t_modes;
      begin
         xfer(1'b1, `PCG_RUN_GATE_OFS, 32'h00000010);
         xfer(1'b1, `PCG_SLEEP_GATE_OFS, 32'h00040001);
         xfer(1'b1, `PCG_DEEP_GATE_OFS, 32'h03000000);
         rdchk(`PCG_SLEEP_GATE_OFS, 32'h00040001);
         rdchk(`PCG_DEEP_GATE_OFS, 32'h03000000);
         xfer(1'b1, `PCG_RUN_CFG_OFS, 32'hFFFFFFFF);
         rdchk(`PCG_RUN_CFG_OFS, 32'h08000000);
         sleep_i <= 1'b1;
         probe(m(32'h00040001));
         deep_sleep_i <= 1'b1;
         probe(m(32'h03000000));
         xfer(1'b1, `PCG_RUN_CFG_OFS, 32'h00000000);
         probe(m(32'h00000010));
      end
   endtask
   // reset in mid-run must clear every gate and the auto-gating select
   task t_rst_again;
      begin
         sleep_i <= 1'b0;
         deep_sleep_i <= 1'b0;
         xfer(1'b1, `PCG_RUN_GATE_OFS, 32'hFFFFFFFF);
         xfer(1'b1, `PCG_RUN_CFG_OFS, 32'hFFFFFFFF);
         reset_i <= 1'b1;
         repeat (3) @(posedge mclk_i);
         reset_i <= 1'b0;
         @(posedge mclk_i);
         rdchk(`PCG_RUN_GATE_OFS, 32'h00000000);
         rdchk(`PCG_RUN_CFG_OFS, 32'h00000000);
         probe(7'h00);
      end
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      t_reset;
      t_fields;
      t_modes;
      t_rst_again;
      conclude;
   end
endmodule
